// ===== hdl/adcs_seq.sv
// adcs_seq: input-mode decode and channel sequencer with its register file.
// assumes: conv_done and conv_busy come from the converter core on hclk.
//
// How it works
// - config bits 00 give eight single-ended inputs against analog ground.
// - config zero clear, one set gives four fully differential pairs.
// - config 0,1 gives four pseudo pairs and 1,1 seven pseudo inputs.
// - in the seven-input mode every input is measured against input 7.
// - selection bits 00 convert the channel in the last address field.
// - selection 0,1 runs through exactly the channels set in a non-empty shadow.
// - after shadow load the lowest enabled channel goes first, then up.
// - after the highest enabled channel the pointer wraps to the lowest.
// - writes with selection 1,0 keep a sequence, any other code ends it.
// - selection 1,1 sweeps from channel 0 to the address field, repeating.
// - the first conversion after a sweep start is on channel 0.
//
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
module adcs_seq
  import adcs_pkg::*;
(
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [ADCS_AW-1:0] haddr,
  input  wire logic [ADCS_DW-1:0] hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic      [ADCS_DW-1:0] hrdata,
  // converter core
  input  wire logic               conv_done,
  input  wire logic               conv_busy,
  // analog multiplexer select
  output logic      [ADCS_CW-1:0] positive_analog_input,
  output logic      [ADCS_CW-1:0] negative_analog_input,
  output logic                    negative_is_agnd,
  output logic      [ADCS_CW-1:0] channel_id
);

  logic               wr_en;
  logic [ADCS_AW-1:0] reg_addr;
  logic [ADCS_DW-1:0] wr_data;
  logic [ADCS_DW-1:0] rd_data;

  adcs_ahb u_ahb (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .haddr     (haddr),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .wr_en     (wr_en),
    .reg_addr  (reg_addr),
    .wr_data   (wr_data),
    .rd_data   (rd_data)
  );

  logic [ADCS_CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [ADCS_NCH-1:0]    shadow_r, shadow_nxt;
  adcs_state_e            state_r, state_nxt;
  logic [ADCS_CW-1:0]     chan_r, chan_nxt;
  logic [ADCS_CW-1:0]     last_r, last_nxt;
  logic [ADCS_CW-1:0]     pos_r, pos_nxt;
  logic [ADCS_CW-1:0]     neg_r, neg_nxt;
  logic                   gnd_r, gnd_nxt;
  logic [ADCS_CW-1:0]     cid_r, cid_nxt;

  logic                   wr_ctrl, wr_shadow;
  logic [1:0]             wsel;
  logic [ADCS_CW-1:0]     waddr;
  logic [1:0]             cfg;
  logic [ADCS_CW-1:0]     low_ch, high_ch, nxt_ch;
  logic                   any_ch;

  adcs_next_ch #(
    .N  (ADCS_NCH),
    .CW (ADCS_CW)
  ) u_next (
    .mask    (shadow_r),
    .cur     (chan_r),
    .lowest  (low_ch),
    .highest (high_ch),
    .next    (nxt_ch),
    .any     (any_ch)
  );

  assign wr_ctrl = wr_en && (reg_addr == ADCS_CTRL_OFS);
  assign wr_shadow = wr_en && (reg_addr == ADCS_SHADOW_OFS);
  assign wsel    = {wr_data[ADCS_SEQ_BIT], wr_data[ADCS_SHSEL_BIT]};
  assign waddr   = wr_data[ADCS_ADDR_LSB +: ADCS_CW];
  // codes are {bit one, bit zero}; swapping them mixes up the pair modes
  assign cfg     = {ctrl_r[ADCS_CFG1_BIT], ctrl_r[ADCS_CFG0_BIT]};

  // register file and sequencer next state
  always_comb begin
    ctrl_nxt  = wr_ctrl ? wr_data[ADCS_CTRL_W-1:0] : ctrl_r;
    shadow_nxt = wr_shadow ? wr_data[ADCS_NCH-1:0] : shadow_r;
    state_nxt = state_r;
    chan_nxt  = chan_r;
    last_nxt  = last_r;
    if (wr_ctrl) begin
      case (wsel)
        ADCS_SEL_DIRECT: begin
          state_nxt = ADCS_ST_DIRECT;
          chan_nxt  = waddr;
        end
        ADCS_SEL_PROG: begin
          state_nxt = ADCS_ST_PROG;
          if (any_ch) begin
            chan_nxt = low_ch;
          end
        end
        ADCS_SEL_CONSEC: begin
          state_nxt = ADCS_ST_CONSEC;
          chan_nxt  = ADCS_FIRST_CH;
          last_nxt  = waddr;
        end
        default: begin
          state_nxt = state_r;
        end
      endcase
    end else if (wr_shadow && state_r == ADCS_ST_PROG) begin
      // a fresh shadow load restarts from its lowest channel
      if (|wr_data[ADCS_NCH-1:0]) begin
        chan_nxt = ADCS_CW'(0);
        for (int i = ADCS_NCH - 1; i >= 0; i--) begin
          if (wr_data[i]) begin
            chan_nxt = ADCS_CW'(i);
          end
        end
      end
    end else if (conv_done) begin
      case (state_r)
        ADCS_ST_PROG: begin
          if (any_ch) begin
            chan_nxt = nxt_ch;
          end
        end
        ADCS_ST_CONSEC: begin
          chan_nxt = (chan_r == last_r) ? ADCS_FIRST_CH
                                        : chan_r + 3'h1;
        end
        ADCS_ST_DIRECT: begin
          chan_nxt = chan_r;
        end
        default: begin
          state_nxt = ADCS_ST_DIRECT;
        end
      endcase
    end
  end

  // multiplexer decode; frozen while the converter holds a sample
  always_comb begin
    pos_nxt = pos_r;
    neg_nxt = neg_r;
    gnd_nxt = gnd_r;
    cid_nxt = cid_r;
    if (!conv_busy) begin
      cid_nxt = chan_r;
      case (cfg)
        ADCS_CFG_SE: begin
          pos_nxt = chan_r;
          neg_nxt = chan_r;
          gnd_nxt = 1'b1;
        end
        ADCS_CFG_DIFF, ADCS_CFG_PSP: begin
          pos_nxt = {chan_r[1:0], 1'b0};
          neg_nxt = {chan_r[1:0], 1'b1};
          gnd_nxt = 1'b0;
        end
        ADCS_CFG_PS7: begin
          pos_nxt = chan_r;
          neg_nxt = ADCS_SHARED_NEG;
          gnd_nxt = 1'b0;
        end
        default: begin
          gnd_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r  <= ADCS_CTRL_RST;
      shadow_r <= ADCS_SHADOW_RST;
      state_r <= ADCS_ST_DIRECT;
      chan_r  <= ADCS_FIRST_CH;
      last_r  <= ADCS_FIRST_CH;
      pos_r   <= ADCS_FIRST_CH;
      neg_r   <= ADCS_FIRST_CH;
      gnd_r   <= 1'b1;
      cid_r   <= ADCS_FIRST_CH;
    end else begin
      ctrl_r  <= ctrl_nxt;
      shadow_r <= shadow_nxt;
      state_r <= state_nxt;
      chan_r  <= chan_nxt;
      last_r  <= last_nxt;
      pos_r   <= pos_nxt;
      neg_r   <= neg_nxt;
      gnd_r   <= gnd_nxt;
      cid_r   <= cid_nxt;
    end
  end

  // unmapped offsets read as zero and ignore writes
  always_comb begin
    rd_data = '0;
    case (reg_addr)
      ADCS_CTRL_OFS: rd_data[ADCS_CTRL_W-1:0] = ctrl_r;
      ADCS_SHADOW_OFS: rd_data[ADCS_NCH-1:0]  = shadow_r;
      ADCS_STAT_OFS: begin
        rd_data[ADCS_ST_CH_LSB +: ADCS_CW]  = chan_r;
        rd_data[ADCS_ST_POS_LSB +: ADCS_CW] = pos_r;
        rd_data[ADCS_ST_NEG_LSB +: ADCS_CW] = neg_r;
        rd_data[ADCS_ST_GND_BIT]            = gnd_r;
        rd_data[ADCS_ST_FSM_LSB +: 3]       = state_r;
      end
      default: rd_data = '0;
    endcase
  end

  assign positive_analog_input = pos_r;
  assign negative_analog_input = neg_r;
  assign negative_is_agnd      = gnd_r;
  assign channel_id            = cid_r;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  se_agnd_a: assert property (
    !conv_busy && cfg == ADCS_CFG_SE |=> gnd_r && pos_r == $past(chan_r))
    else $error("single-ended input not tied to ground");

  diff_pair_a: assert property (
    !conv_busy && cfg == ADCS_CFG_DIFF
    |=> !gnd_r && neg_r == pos_r + 3'h1 && !pos_r[0])
    else $error("differential pair wrongly formed");

  pseudo7_neg_a: assert property (
    !conv_busy && cfg == ADCS_CFG_PS7 |=> !gnd_r && neg_r == 3'h7)
    else $error("seven-input mode lost shared negative");

  direct_addr_a: assert property (
    wr_ctrl && wsel == ADCS_SEL_DIRECT
    |=> chan_r == $past(waddr) && state_r == ADCS_ST_DIRECT)
    else $error("direct write did not select channel");

  prog_wrap_a: assert property (
    state_r == ADCS_ST_PROG && conv_done && !wr_en && any_ch
    && chan_r == high_ch |=> chan_r == $past(low_ch))
    else $error("programmed sequence did not wrap");

  prog_step_a: assert property (
    state_r == ADCS_ST_PROG && conv_done && !wr_en && any_ch
    && chan_r < high_ch |=> chan_r > $past(chan_r) && shadow_r[chan_r])
    else $error("programmed sequence did not step up");

  keep_seq_a: assert property (
    wr_ctrl && wsel == ADCS_SEL_KEEP && !conv_done
    |=> $stable(state_r) && $stable(chan_r))
    else $error("keep-going write disturbed sequence");

  sweep_start_a: assert property (
    wr_ctrl && wsel == ADCS_SEL_CONSEC
    |=> chan_r == 3'h0 && last_r == $past(waddr)
    ##1 ($past(conv_busy) || cid_r == 3'h0))
    else $error("sweep did not start on channel 0");

  sweep_wrap_a: assert property (
    state_r == ADCS_ST_CONSEC && conv_done && !wr_en && chan_r == last_r
    |=> chan_r == 3'h0)
    else $error("sweep did not restart at channel 0");

  busy_hold_a: assert property (
    conv_busy [*2] |-> $stable(pos_r) && $stable(neg_r) && $stable(cid_r))
    else $error("mux select moved during conversion");

  prog_run_c: cover property (
    state_r == ADCS_ST_PROG && conv_done ##1 conv_done[*1]);
  sweep_wrap_c: cover property (
    state_r == ADCS_ST_CONSEC && conv_done && chan_r == last_r && chan_r != 0);
  keep_write_c: cover property (
    state_r != ADCS_ST_DIRECT && wr_ctrl && wsel == ADCS_SEL_KEEP);
  pseudo7_c: cover property (cfg == ADCS_CFG_PS7 && !conv_busy);
  sweep_start_c: cover property (wr_ctrl && wsel == ADCS_SEL_CONSEC);

  psp_pair_a: assert property (
    !conv_busy && cfg == ADCS_CFG_PSP
    |=> !gnd_r && pos_r == {$past(chan_r[1:0]), 1'b0}
    && neg_r == pos_r + 3'h1)
    else $error("pseudo pair wrongly formed");

  prog_empty_a: assert property (
    wr_ctrl && wsel == ADCS_SEL_PROG && !any_ch |=> $stable(chan_r))
    else $error("empty shadow moved the channel");

endmodule : adcs_seq

// ===== hdl/adcs_pkg.sv
// adcs_pkg: register map, field positions, reset values and sequencer states
// of the input-mode and channel sequencer; shared by adcs_seq, adcs_ahb and the bench.
package adcs_pkg;

  localparam int          ADCS_DW        = 32;
  localparam int          ADCS_AW        = 12;
  localparam int          ADCS_NCH       = 8;
  localparam int          ADCS_CW        = 3;

  // register byte offsets
  localparam logic [11:0] ADCS_CTRL_OFS  = 12'h000;
  localparam logic [11:0] ADCS_SHADOW_OFS = 12'h004;
  localparam logic [11:0] ADCS_STAT_OFS  = 12'h008;

  // control register fields
  localparam int          ADCS_ADDR_LSB  = 0;
  localparam int          ADCS_SHSEL_BIT = 3;
  localparam int          ADCS_SEQ_BIT   = 4;
  localparam int          ADCS_CFG0_BIT  = 5;
  localparam int          ADCS_CFG1_BIT  = 6;
  localparam int          ADCS_CTRL_W    = 7;

  // status register fields
  localparam int          ADCS_ST_CH_LSB  = 0;
  localparam int          ADCS_ST_POS_LSB = 3;
  localparam int          ADCS_ST_NEG_LSB = 6;
  localparam int          ADCS_ST_GND_BIT = 9;
  localparam int          ADCS_ST_FSM_LSB = 10;

  // reset values
  localparam logic [6:0]  ADCS_CTRL_RST  = 7'h00;
  localparam logic [7:0]  ADCS_SHADOW_RST = 8'h00;

  // fixed input numbers
  localparam logic [2:0]  ADCS_SHARED_NEG = 3'h7;
  localparam logic [2:0]  ADCS_FIRST_CH   = 3'h0;

  // input configuration codes {bit one, bit zero}
  localparam logic [1:0]  ADCS_CFG_SE    = 2'b00;
  localparam logic [1:0]  ADCS_CFG_DIFF  = 2'b10;
  localparam logic [1:0]  ADCS_CFG_PSP   = 2'b01;
  localparam logic [1:0]  ADCS_CFG_PS7   = 2'b11;

  // selection codes {sequence bit, shadow-select bit}
  localparam logic [1:0]  ADCS_SEL_DIRECT = 2'b00;
  localparam logic [1:0]  ADCS_SEL_PROG   = 2'b01;
  localparam logic [1:0]  ADCS_SEL_KEEP   = 2'b10;
  localparam logic [1:0]  ADCS_SEL_CONSEC = 2'b11;

  typedef enum logic [2:0] {
    ADCS_ST_DIRECT = 3'b001,
    ADCS_ST_PROG   = 3'b010,
    ADCS_ST_CONSEC = 3'b100
  } adcs_state_e;

endpackage : adcs_pkg

// ===== hdl/adcs_next_ch.sv
// adcs_next_ch: finds the lowest set bit of a channel mask and the next set
// bit above a given channel, wrapping to the lowest.
// assumes: purely combinational, mask and channel from the same clock.
`timescale 1ns/100ps
module adcs_next_ch #(
  parameter int N  = 8,
  parameter int CW = 3
) (
  // channel mask and present channel
  input  wire logic [N-1:0]  mask,
  input  wire logic [CW-1:0] cur,
  // results
  output logic      [CW-1:0] lowest,
  output logic      [CW-1:0] highest,
  output logic      [CW-1:0] next,
  output logic               any
);

  // one mask bit per channel code, so the pointer can never leave the mask
  if (N != (1 << CW)) begin : g_bad_size
    $error("adcs_next_ch: N must be 2**CW");
  end

  logic          found;
  logic [CW-1:0] above;

  always_comb begin
    lowest  = '0;
    highest = '0;
    above   = '0;
    found   = 1'b0;
    any     = |mask;
    for (int i = N - 1; i >= 0; i--) begin
      if (mask[i]) begin
        lowest = CW'(i);
        if (i > int'(cur)) begin
          above = CW'(i);
          found = 1'b1;
        end
      end
    end
    for (int i = 0; i < N; i++) begin
      if (mask[i]) begin
        highest = CW'(i);
      end
    end
    next = found ? above : lowest;
  end

endmodule : adcs_next_ch

// ===== hdl/adcs_ahb.sv
// adcs_ahb: AHB-Lite slave front end; turns bus transfers into a register
// write strobe and a word address, and registers the read data.
// assumes: single slave, so hready equals our hreadyout; response always OKAY.
`timescale 1ns/100ps
module adcs_ahb
  import adcs_pkg::*;
(
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [ADCS_AW-1:0] haddr,
  input  wire logic [ADCS_DW-1:0] hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic      [ADCS_DW-1:0] hrdata,
  // register side
  output logic                    wr_en,
  output logic      [ADCS_AW-1:0] reg_addr,
  output logic      [ADCS_DW-1:0] wr_data,
  input  wire logic [ADCS_DW-1:0] rd_data
);

  logic               wr_pend_r, wr_pend_nxt;
  logic [1:0]         rd_ph_r, rd_ph_nxt;
  logic [ADCS_AW-1:0] addr_r, addr_nxt;
  logic [ADCS_DW-1:0] rdata_r, rdata_nxt;
  logic               take;

  // read data phase lasts two cycles so a write just before is visible
  always_comb begin
    take        = hsel && htrans[1] && hready;
    wr_pend_nxt = take && hwrite;
    addr_nxt    = take ? {haddr[ADCS_AW-1:2], 2'b00} : addr_r;
    rd_ph_nxt   = 2'b00;
    if (take && !hwrite) begin
      rd_ph_nxt = 2'b01;
    end else if (rd_ph_r == 2'b01) begin
      rd_ph_nxt = 2'b10;
    end
    rdata_nxt   = (rd_ph_r == 2'b01) ? rd_data : rdata_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_ph_r   <= 2'b00;
      addr_r    <= '0;
      rdata_r   <= '0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      rd_ph_r   <= rd_ph_nxt;
      addr_r    <= addr_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign hreadyout = (rd_ph_r != 2'b01);
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;
  assign wr_en     = wr_pend_r;
  assign reg_addr  = addr_r;
  assign wr_data   = hwdata;

endmodule : adcs_ahb

// ===== tb/adcs_host.sv
// adcs_host: host side model, single word transfers on ahb-lite.
// assumes: one slave, whose hreadyout comes back as hready.
`timescale 1ns/100ps
module adcs_host
  import adcs_pkg::*;
(
  // clock
  input  wire logic               hclk,
  // ahb-lite master
  output logic                    hsel,
  output logic      [1:0]         htrans,
  output logic                    hwrite,
  output logic      [2:0]         hsize,
  output logic      [ADCS_AW-1:0] haddr,
  output logic      [ADCS_DW-1:0] hwdata,
  input  wire logic               hready,
  input  wire logic [ADCS_DW-1:0] hrdata
);
  initial begin
    hsel   = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'b010;
    haddr  = '0;
    hwdata = '0;
  end

  // bounded wait, so a stuck slave cannot hang the run
  task automatic wait_rdy(output logic ok);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    ok = (hready === 1'b1);
  endtask : wait_rdy

  // the bus is idle outside a transfer, so nothing disturbs a sequence
  task automatic xfer(input  logic               wr,
                      input  logic [ADCS_AW-1:0] a,
                      input  logic [ADCS_DW-1:0] wd,
                      output logic [ADCS_DW-1:0] rd,
                      output logic               ok);
    logic ok1;
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= a;
    wait_rdy(ok1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy(ok);
    rd = hrdata;
    ok = ok & ok1;
  endtask : xfer
endmodule : adcs_host

// ===== tb/test_adc_input_mode_channel_sequencer.sv
// test_adc_input_mode_channel_sequencer: bus-level tests of input modes
// and channel sequencing. assumes: the bench plays the converter core.
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module test_adc_input_mode_channel_sequencer;
  import adcs_pkg::*;
  logic               hclk;
  logic               hresetn;
  logic               hsel;
  logic [1:0]         htrans;
  logic               hwrite;
  logic [2:0]         hsize;
  logic [ADCS_AW-1:0] haddr;
  logic [ADCS_DW-1:0] hwdata;
  logic               hreadyout;
  logic               hresp;
  logic [ADCS_DW-1:0] hrdata;
  logic               conv_done;
  logic               conv_busy;
  logic [ADCS_CW-1:0] pos;
  logic [ADCS_CW-1:0] neg;
  logic               agnd;
  logic [ADCS_CW-1:0] chan;
  logic [1:0]         cf;
  logic [2:0]         a;
  int                 mismatches;
  int                 checks;

  adcs_seq dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .haddr(haddr), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .conv_done(conv_done), .conv_busy(conv_busy),
    .positive_analog_input(pos), .negative_analog_input(neg),
    .negative_is_agnd(agnd), .channel_id(chan)
  );

  adcs_host host (
    .hclk(hclk), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .haddr(haddr), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata)
  );

  always #2.5 hclk = ~hclk;

  task automatic give_verdict;
    if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic bus(input logic wr, input logic [ADCS_AW-1:0] ad,
                     input logic [ADCS_DW-1:0] d, m);
    logic               ok;
    logic [ADCS_DW-1:0] x;
    host.xfer(wr, ad, d, x, ok);
    `CHK(hresp, 1'b0)
    if (!ok) begin
      mismatches++;
      give_verdict();
    end
    if (!wr) `CHK(x & m, d)
    repeat (2) @(posedge hclk);
    #1;
  endtask : bus

  // control write: {bit one, bit zero}, {sequence, shadow select}, address
  task automatic ctl(input logic [1:0] c, s, input logic [2:0] ad);
    bus(1'b1, ADCS_CTRL_OFS, {25'h0, c, s, ad}, '0);
  endtask : ctl

  task automatic mux(input logic [2:0] c, p, n, input logic g);
    `CHK(chan, c)
    `CHK(pos, p)
    if (!g) `CHK(neg, n)
    `CHK(agnd, g)
  endtask : mux

  // done arrives while busy still holds the sample; inputs must not move
  // channel_id and the selects are frozen together until busy drops
  task automatic conv(input logic [2:0] c);
    logic [2:0] was;
    logic [2:0] wch;
    was = pos;
    wch = chan;
    @(posedge hclk);
    conv_busy <= 1'b1;
    @(posedge hclk);
    conv_done <= 1'b1;
    @(posedge hclk);
    conv_done <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
    `CHK(chan, wch)
    `CHK(pos, was)
    @(posedge hclk);
    conv_busy <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
    `CHK(chan, c)
    `CHK(pos, c)
  endtask : conv

  initial begin
    repeat (50000) @(posedge hclk);
    mismatches++;
    give_verdict();
  end

  initial begin
    hclk       = 1'b0;
    hresetn    = 1'b0;
    conv_done  = 1'b0;
    conv_busy  = 1'b0;
    mismatches = 0;
    checks     = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    mux(3'h0, 3'h0, 3'h0, 1'b1);
    bus(1'b0, ADCS_CTRL_OFS, 32'h0000_0000, 32'hffff_ffff);
    bus(1'b0, ADCS_SHADOW_OFS, 32'h0000_0000, 32'hffff_ffff);
    bus(1'b0, ADCS_STAT_OFS, 32'h0000_0600, 32'hffff_ffff);
    bus(1'b1, 12'h00c, 32'hffff_ffff, '0);
    bus(1'b0, 12'h00c, 32'h0000_0000, 32'hffff_ffff);
    // every input configuration against every address
    for (int k = 0; k < 32; k++) begin
      cf = k[4:3];
      a  = k[2:0];
      ctl(cf, 2'b00, a);
      if (cf == 2'b00) mux(a, a, 3'h0, 1'b1);
      else if (cf == 2'b11) mux(a, a, 3'h7, 1'b0);
      else mux(a, {a[1:0], 1'b0}, {a[1:0], 1'b1}, 1'b0);
    end
    bus(1'b0, ADCS_CTRL_OFS, 32'h0000_0067, 32'hffff_ffff);
    ctl(2'b00, 2'b00, 3'h5);
    conv(3'h5);
    // programmed sequence; an empty shadow leaves the channel alone
    ctl(2'b00, 2'b01, 3'h0);
    `CHK(chan, 3'h5)
    conv(3'h5);
    bus(1'b1, ADCS_SHADOW_OFS, 32'h0000_0094, '0);
    `CHK(chan, 3'h2)
    bus(1'b0, ADCS_SHADOW_OFS, 32'h0000_0094, 32'h0000_00ff);
    bus(1'b0, ADCS_STAT_OFS, 32'h0000_0800, 32'h0000_1c00);
    conv(3'h4);
    conv(3'h7);
    conv(3'h2);
    ctl(2'b00, 2'b10, 3'h1);
    conv(3'h4);
    conv(3'h7);
    ctl(2'b00, 2'b00, 3'h3);
    conv(3'h3);
    // consecutive sweep; the end is fixed by the write that starts it
    ctl(2'b00, 2'b11, 3'h2);
    `CHK(chan, 3'h0)
    bus(1'b0, ADCS_STAT_OFS, 32'h0000_1000, 32'h0000_1c00);
    conv(3'h1);
    conv(3'h2);
    conv(3'h0);
    ctl(2'b00, 2'b10, 3'h5);
    conv(3'h1);
    conv(3'h2);
    conv(3'h0);
    ctl(2'b00, 2'b11, 3'h7);
    for (int k = 1; k < 9; k++) begin
      conv(k[2:0]);
    end
    // a reset in mid-run drops the block back to its idle selection
    ctl(2'b11, 2'b00, 3'h6);
    mux(3'h6, 3'h6, 3'h7, 1'b0);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    mux(3'h0, 3'h0, 3'h0, 1'b1);
    bus(1'b0, ADCS_STAT_OFS, 32'h0000_0600, 32'hffff_ffff);
    bus(1'b0, ADCS_CTRL_OFS, 32'h0000_0000, 32'hffff_ffff);
    give_verdict();
  end
endmodule : test_adc_input_mode_channel_sequencer
